/* File: rtl/hic_pkg.sv */
// Purpose: Shared constants and carriers for the host interface config block
// Assumes: 32-bit Avalon-MM register words, byte addressed
// Notes:   Every offset lives here, and every field position and reset value except those of the counters word
package hic_pkg;

    // =========================================================
    // Register map (byte addresses)
    // =========================================================
    localparam logic [4:0] OFF_CONFIG_ONE = 5'h00;
    localparam logic [4:0] OFF_ULTRA_LOW = 5'h04;
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h08;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h0c;
    localparam logic [4:0] OFF_SEQ_STATUS = 5'h10;
    localparam logic [4:0] OFF_COUNTERS = 5'h14;

    // =========================================================
    // host_interface_config_one fields
    // =========================================================
    localparam int CFG_DMA_SUSPEND = 7;
    localparam int CFG_SHHP_OFF = 6;
    localparam int CFG_UDMA_AUTO_OFF = 5;
    localparam int CFG_FLUSH = 4;
    localparam int CFG_UNMASK = 2;
    localparam int CFG_CLEAR = 1;
    localparam int CFG_ULTRA_BIT3 = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [2:0] ULTRA_LOW_RESET = 3'h0;

    // =========================================================
    // Interrupt status / mask layout
    // =========================================================
    localparam int IRQ_W = 3;
    localparam int IRQ_DTEI = 0;
    localparam int IRQ_SUSPEND = 1;
    localparam int IRQ_XFER_END = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    // =========================================================
    // Sequencer status word fields
    // =========================================================
    localparam int ST_SUSPENDED = 0;
    localparam int ST_BSY = 1;
    localparam int ST_DRQ = 2;
    localparam int ST_DTEI_FLAG = 6;
    localparam int ST_WPTR_LSB = 8;

    // =========================================================
    // Sizes
    // =========================================================
    localparam int CMD_FIFO_DEPTH = 12;
    localparam int PTR_W = 4;
    localparam int CNT_W = 16;
    localparam int LIMIT_W = 8;
    localparam int ULTRA_W = 4;

    // Sequencer states
    typedef enum logic [2:0] {
        SEQ_RUN = 3'b001,
        SEQ_SUSP = 3'b010,
        SEQ_RESUME = 3'b100
    } hic_seq_state_t;

    // Events from the host side of the interface
    typedef struct packed {
        logic cmd_byte_wr;
        logic word_xfer;
        logic pkt_load;
        logic [CNT_W-1:0] pkt_size;
        logic dtei_event;
        logic dtei_ack;
        logic xfer_end;
        logic autodrq_on;
        logic bsy_req;
        logic drq_req;
    } hic_seq_in_t;

    // Registered controls toward the host interface
    typedef struct packed {
        logic host_bsy;
        logic host_drq;
        logic dtei_flag;
        logic dtei_irq;
        logic ultra_en_clr;
        logic dma_suspend_en;
        logic shhp_off;
    } hic_seq_out_t;

endpackage

/* File: rtl/hic_cmd_counters.sv */
// Purpose: Command FIFO write pointer, transfer counter and packet size store
// Assumes: Flush and clear arrive as one-cycle strobes
// Notes:   Flush and clear win over a same-cycle increment or load
module hic_cmd_counters #(
    parameter int DEPTH = hic_pkg::CMD_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Strobes
    input wire logic flush,
    input wire logic clear,
    // Events
    input wire logic cmd_byte_wr,
    input wire logic word_xfer,
    input wire logic pkt_load,
    input wire logic [hic_pkg::CNT_W-1:0] pkt_size_in,
    // State
    output logic [hic_pkg::PTR_W-1:0] wptr,
    output logic [hic_pkg::CNT_W-1:0] xfer_cnt,
    output logic [hic_pkg::CNT_W-1:0] pkt_size
);

    localparam logic [hic_pkg::PTR_W-1:0] LAST = hic_pkg::PTR_W'(DEPTH);

    logic [hic_pkg::PTR_W-1:0] wptr_next;
    logic [hic_pkg::CNT_W-1:0] xfer_cnt_next;
    logic [hic_pkg::CNT_W-1:0] pkt_size_next;

    always_comb
    begin
        wptr_next = wptr;
        xfer_cnt_next = xfer_cnt;
        pkt_size_next = pkt_size;
        if (flush)
        begin
            wptr_next = '0;
        end
        else if (cmd_byte_wr && wptr != LAST)
        begin
            wptr_next = wptr + 1'b1;
        end
        if (clear)
        begin
            xfer_cnt_next = '0;
            pkt_size_next = '0;
        end
        else
        begin
            if (word_xfer)
            begin
                xfer_cnt_next = xfer_cnt + 1'b1;
            end
            if (pkt_load)
            begin
                pkt_size_next = pkt_size_in;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            wptr <= '0;
            xfer_cnt <= '0;
            pkt_size <= '0;
        end
        else
        begin
            wptr <= wptr_next;
            xfer_cnt <= xfer_cnt_next;
            pkt_size <= pkt_size_next;
        end
    end

endmodule // hic_cmd_counters

/* File: rtl/hic_udma_timer.sv */
// Purpose: Ultra DMA timing limit counter with configurable extension
// Assumes: start is a one-cycle pulse; base limit plus extension of zero acts as one
// Notes:   A start while busy restarts the count
module hic_udma_timer (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Request
    input wire logic start,
    input wire logic [hic_pkg::LIMIT_W-1:0] base_limit,
    input wire logic [hic_pkg::ULTRA_W-1:0] extra,
    // Result
    output logic busy,
    output logic done
);

    localparam int SUM_W = hic_pkg::LIMIT_W + 1;

    logic [SUM_W-1:0] count;
    logic [SUM_W-1:0] count_next;
    logic busy_next;
    logic done_next;
    logic [SUM_W-1:0] total;

    always_comb
    begin
        total = SUM_W'(base_limit) + SUM_W'(extra);
        if (total == '0)
        begin
            total = SUM_W'(1);
        end
        count_next = count;
        busy_next = busy;
        done_next = 1'b0;
        if (start)
        begin
            count_next = total;
            busy_next = 1'b1;
        end
        else if (busy)
        begin
            if (count == SUM_W'(1))
            begin
                busy_next = 1'b0;
                done_next = 1'b1;
                count_next = '0;
            end
            else
            begin
                count_next = count - 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            count <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            count <= count_next;
            busy <= busy_next;
            done <= done_next;
        end
    end

endmodule // hic_udma_timer

/* File: rtl/hic_config_top.sv */
// Purpose: Host interface config register bank and auto sequencer controls
// Assumes: Avalon-MM slave, one clock, host events synchronous to clock
// Notes:   Each access answers one cycle after it is seen
module hic_config_top (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [4:0] address,
    input wire logic [3:0] byteenable,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Host side events
    input wire hic_pkg::hic_seq_in_t seq_in,
    // Ultra DMA timing request
    input wire logic udma_start,
    input wire logic [hic_pkg::LIMIT_W-1:0] udma_base_limit,
    // Controls toward the host interface
    output hic_pkg::hic_seq_out_t seq_out,
    output logic udma_busy,
    output logic udma_done,
    // Interrupt
    output logic irq
);

    // =========================================================
    // Bus slave
    // =========================================================
    logic [31:0] readdata_next;
    logic waitrequest_next;
    logic req;
    logic take;
    logic wr_lane0;

    assign req = read | write;
    // Access completes at the edge where waitrequest is low
    assign take = req & ~waitrequest;
    assign wr_lane0 = take & write & byteenable[0];

    // =========================================================
    // Register state
    // =========================================================
    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;
    logic [2:0] ultra_low_reg;
    logic [2:0] ultra_low_next;
    logic [hic_pkg::IRQ_W-1:0] irq_status_reg;
    logic [hic_pkg::IRQ_W-1:0] irq_status_next;
    logic [hic_pkg::IRQ_W-1:0] irq_mask_reg;
    logic [hic_pkg::IRQ_W-1:0] irq_mask_next;
    logic flush_reg;
    logic flush_next;
    logic clear_reg;
    logic clear_next;
    logic irq_next;
    logic [hic_pkg::IRQ_W-1:0] irq_events;

    logic [hic_pkg::ULTRA_W-1:0] ultra_field;
    logic unmask;

    // field msb from config bit 0
    assign ultra_field = {cfg_reg[hic_pkg::CFG_ULTRA_BIT3], ultra_low_reg};
    assign unmask = cfg_reg[hic_pkg::CFG_UNMASK];

    // =========================================================
    // Sequencer state
    // =========================================================
    hic_pkg::hic_seq_state_t state_reg;
    hic_pkg::hic_seq_state_t state_next;
    hic_pkg::hic_seq_out_t out_next;
    logic dtei_flag_next;
    logic enter_susp;

    // Counters
    logic [hic_pkg::PTR_W-1:0] wptr;
    logic [hic_pkg::CNT_W-1:0] xfer_cnt;
    logic [hic_pkg::CNT_W-1:0] pkt_size;

    hic_cmd_counters #(
        .DEPTH(hic_pkg::CMD_FIFO_DEPTH)
    ) u_counters (
        .clock(clock),
        .rstn(rstn),
        .flush(flush_reg),
        .clear(clear_reg),
        .cmd_byte_wr(seq_in.cmd_byte_wr),
        .word_xfer(seq_in.word_xfer),
        .pkt_load(seq_in.pkt_load),
        .pkt_size_in(seq_in.pkt_size),
        .wptr(wptr),
        .xfer_cnt(xfer_cnt),
        .pkt_size(pkt_size)
    );

    hic_udma_timer u_timer (
        .clock(clock),
        .rstn(rstn),
        .start(udma_start),
        .base_limit(udma_base_limit),
        .extra(ultra_field),
        .busy(udma_busy),
        .done(udma_done)
    );

    // =========================================================
    // Register writes and interrupts
    // =========================================================
    always_comb
    begin
        cfg_next = cfg_reg;
        ultra_low_next = ultra_low_reg;
        irq_mask_next = irq_mask_reg;
        irq_status_next = irq_status_reg;
        flush_next = 1'b0;
        clear_next = 1'b0;
        if (wr_lane0)
        begin
            case (address)
                hic_pkg::OFF_CONFIG_ONE:
                begin
                    cfg_next = writedata[7:0];
                    // Strobe bits never stored
                    cfg_next[hic_pkg::CFG_FLUSH] = 1'b0;
                    cfg_next[hic_pkg::CFG_CLEAR] = 1'b0;
                    cfg_next[3] = 1'b0;
                    flush_next = writedata[hic_pkg::CFG_FLUSH];
                    clear_next = writedata[hic_pkg::CFG_CLEAR];
                end
                hic_pkg::OFF_ULTRA_LOW:
                begin
                    ultra_low_next = writedata[2:0];
                end
                hic_pkg::OFF_IRQ_STATUS:
                begin
                    irq_status_next = irq_status_reg & ~writedata[hic_pkg::IRQ_W-1:0];
                end
                hic_pkg::OFF_IRQ_MASK:
                begin
                    irq_mask_next = writedata[hic_pkg::IRQ_W-1:0];
                end
                default:
                begin
                    cfg_next = cfg_reg;
                end
            endcase
        end
        // Set wins over a same-cycle write-one clear
        irq_status_next = irq_status_next | irq_events;
        irq_next = |(irq_status_next & irq_mask_next);
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg_reg <= hic_pkg::CFG_RESET;
            ultra_low_reg <= hic_pkg::ULTRA_LOW_RESET;
            irq_status_reg <= hic_pkg::IRQ_RESET;
            irq_mask_reg <= hic_pkg::IRQ_RESET;
            flush_reg <= 1'b0;
            clear_reg <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            cfg_reg <= cfg_next;
            ultra_low_reg <= ultra_low_next;
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
            flush_reg <= flush_next;
            clear_reg <= clear_next;
            irq <= irq_next;
        end
    end

    // =========================================================
    // Auto sequencer suspend and resume
    // =========================================================
    always_comb
    begin
        state_next = state_reg;
        out_next = seq_out;
        dtei_flag_next = seq_out.dtei_flag;
        enter_susp = (state_reg == hic_pkg::SEQ_RUN) & unmask & seq_in.autodrq_on
            & seq_in.dtei_event;
        case (state_reg)
            hic_pkg::SEQ_RUN:
            begin
                if (enter_susp)
                begin
                    state_next = hic_pkg::SEQ_SUSP;
                end
            end
            hic_pkg::SEQ_SUSP:
            begin
                if (!unmask)
                begin
                    state_next = hic_pkg::SEQ_RESUME;
                end
            end
            hic_pkg::SEQ_RESUME:
            begin
                state_next = hic_pkg::SEQ_RUN;
            end
            default:
            begin
                state_next = hic_pkg::SEQ_RUN;
            end
        endcase
        if (seq_in.dtei_event)
        begin
            dtei_flag_next = 1'b1;
        end
        else if (state_reg == hic_pkg::SEQ_RESUME || seq_in.dtei_ack)
        begin
            dtei_flag_next = 1'b0;
        end
        out_next.dtei_flag = dtei_flag_next;
        out_next.dtei_irq = dtei_flag_next & (unmask | ~seq_in.autodrq_on);
        if (state_next == hic_pkg::SEQ_SUSP)
        begin
            out_next.host_bsy = 1'b1;
            out_next.host_drq = 1'b0;
        end
        else
        begin
            out_next.host_bsy = seq_in.bsy_req;
            out_next.host_drq = seq_in.drq_req;
        end
        out_next.ultra_en_clr = seq_in.xfer_end & ~cfg_reg[hic_pkg::CFG_UDMA_AUTO_OFF];
        out_next.dma_suspend_en = cfg_reg[hic_pkg::CFG_DMA_SUSPEND];
        out_next.shhp_off = cfg_reg[hic_pkg::CFG_SHHP_OFF];
        irq_events = '0;
        irq_events[hic_pkg::IRQ_DTEI] = seq_in.dtei_event;
        irq_events[hic_pkg::IRQ_SUSPEND] = enter_susp;
        irq_events[hic_pkg::IRQ_XFER_END] = seq_in.xfer_end;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= hic_pkg::SEQ_RUN;
            seq_out <= '0;
        end
        else
        begin
            state_reg <= state_next;
            seq_out <= out_next;
        end
    end

    // =========================================================
    // Read path and waitrequest
    // =========================================================
    always_comb
    begin
        readdata_next = readdata;
        waitrequest_next = 1'b1;
        // Answer one cycle after the request is first seen
        if (req && waitrequest)
        begin
            waitrequest_next = 1'b0;
            readdata_next = '0;
            case (address)
                hic_pkg::OFF_CONFIG_ONE:
                begin
                    readdata_next[7:0] = cfg_reg;
                end
                hic_pkg::OFF_ULTRA_LOW:
                begin
                    readdata_next[2:0] = ultra_low_reg;
                end
                hic_pkg::OFF_IRQ_STATUS:
                begin
                    readdata_next[hic_pkg::IRQ_W-1:0] = irq_status_reg;
                end
                hic_pkg::OFF_IRQ_MASK:
                begin
                    readdata_next[hic_pkg::IRQ_W-1:0] = irq_mask_reg;
                end
                hic_pkg::OFF_SEQ_STATUS:
                begin
                    readdata_next[hic_pkg::ST_SUSPENDED] = (state_reg == hic_pkg::SEQ_SUSP);
                    readdata_next[hic_pkg::ST_BSY] = seq_out.host_bsy;
                    readdata_next[hic_pkg::ST_DRQ] = seq_out.host_drq;
                    readdata_next[hic_pkg::ST_DTEI_FLAG] = seq_out.dtei_flag;
                    readdata_next[hic_pkg::ST_WPTR_LSB +: hic_pkg::PTR_W] = wptr;
                end
                hic_pkg::OFF_COUNTERS:
                begin
                    readdata_next = {pkt_size, xfer_cnt};
                end
                default:
                begin
                    readdata_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            readdata <= '0;
            waitrequest <= 1'b1;
        end
        else
        begin
            readdata <= readdata_next;
            waitrequest <= waitrequest_next;
        end
    end

endmodule // hic_config_top

/* File: tb/hic_config_properties.sv */
// Purpose: Port-level checks on the host interface config block
// Assumes: One clock, async active-low reset
// Notes:   Config and mask shadow finished writes
module hic_config_properties (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Avalon-MM
    input wire logic [4:0] address,
    input wire logic [3:0] byteenable,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Sequencer and interrupt
    input wire hic_pkg::hic_seq_in_t seq_in,
    input wire hic_pkg::hic_seq_out_t seq_out,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;
    logic [2:0] mask_reg;
    logic [2:0] mask_next;
    logic wr_ok;

    // ==========================================================
    // Shadows
    // ==========================================================
    always_comb
    begin
        wr_ok = write && !waitrequest && byteenable[0];
        cfg_next = cfg_reg;
        mask_next = mask_reg;
        if (wr_ok && address == hic_pkg::OFF_CONFIG_ONE)
            cfg_next = writedata[7:0];
        if (wr_ok && address == hic_pkg::OFF_IRQ_MASK)
            mask_next = writedata[2:0];
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg_reg <= 8'h00;
            mask_reg <= 3'h0;
        end
        else
        begin
            cfg_reg <= cfg_next;
            mask_reg <= mask_next;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("access not answered");
    a_wait_single: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    a_ultra_clear: assert property (
        seq_in.xfer_end && !cfg_reg[hic_pkg::CFG_UDMA_AUTO_OFF] |=> seq_out.ultra_en_clr)
        else $error("ultra enable clear missing");
    a_ultra_keep: assert property (
        !(seq_in.xfer_end && !cfg_reg[hic_pkg::CFG_UDMA_AUTO_OFF]) |=> !seq_out.ultra_en_clr)
        else $error("ultra enable clear without cause");
    a_suspend_entry: assert property (
        seq_in.dtei_event && seq_in.autodrq_on && cfg_reg[hic_pkg::CFG_UNMASK]
        |=> seq_out.host_bsy && !seq_out.host_drq)
        else $error("no busy on suspend");
    a_flag_set: assert property (seq_in.dtei_event |=> seq_out.dtei_flag)
        else $error("transfer end flag not set");
    a_strobe_zero: assert property (
        read && !waitrequest && address == hic_pkg::OFF_CONFIG_ONE
        |-> !readdata[hic_pkg::CFG_FLUSH] && !readdata[hic_pkg::CFG_CLEAR])
        else $error("strobe bit reads as one");
    a_unmapped_zero: assert property (
        read && !waitrequest && address > hic_pkg::OFF_COUNTERS |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    a_irq_masked: assert property (mask_reg == 3'h0 ##1 mask_reg == 3'h0 |-> !irq)
        else $error("irq while all masked");
endmodule // hic_config_properties

bind hic_config_top hic_config_properties u_props (
    .clock(clock), .rstn(rstn), .address(address), .byteenable(byteenable),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .seq_in(seq_in), .seq_out(seq_out), .irq(irq)
);

/* File: tb/hic_host_model.sv */
// Purpose: Host adapter side events and timer requests
// Assumes: Tasks are called just after a rising edge
// Notes:   Released packet size shows its inverse
module hic_host_model (
    // Clock
    input wire logic clock,
    // Toward the block
    output hic_pkg::hic_seq_in_t seq_in,
    output logic udma_start,
    output logic [hic_pkg::LIMIT_W-1:0] udma_base_limit
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        seq_in = '0;
        udma_start = 1'b0;
        udma_base_limit = 8'h00;
    end

    // ==========================================================
    // Events: {cmd byte, word, packet load, transfer end irq, end}
    // ==========================================================
    task automatic pulse(input logic [4:0] which, input logic [15:0] size);
        @(posedge clock);
        {seq_in.cmd_byte_wr, seq_in.word_xfer, seq_in.pkt_load} <= which[4:2];
        {seq_in.dtei_event, seq_in.xfer_end} <= which[1:0];
        seq_in.pkt_size <= size;
        @(posedge clock);
        {seq_in.cmd_byte_wr, seq_in.word_xfer, seq_in.pkt_load} <= 3'h0;
        {seq_in.dtei_event, seq_in.xfer_end} <= 2'h0;
        seq_in.pkt_size <= ~size;
    endtask

    task automatic levels(input logic autodrq, input logic bsy, input logic drq);
        @(posedge clock);
        seq_in.autodrq_on <= autodrq;
        seq_in.bsy_req <= bsy;
        seq_in.drq_req <= drq;
    endtask

    task automatic start_timer(input logic [7:0] base);
        @(posedge clock);
        udma_start <= 1'b1;
        udma_base_limit <= base;
        @(posedge clock);
        udma_start <= 1'b0;
    endtask
endmodule // hic_host_model

/* File: tb/hic_config_tb_top.sv */
// Purpose: Self-checking bench for the config block
// Assumes: Bench acts as firmware, host model raises events
// Notes:   Only byte lane 0 carries writable fields, so byteenable is fixed
module host_if_sequencer_config_controls_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    hic_pkg::hic_seq_in_t seq_in;
    hic_pkg::hic_seq_out_t seq_out;
    logic udma_start;
    logic [7:0] udma_base_limit;
    logic irq;
    logic [31:0] rd;
    int n_fail = 0;
    int n_compared = 0;

    always #2 clock = ~clock;

    hic_host_model u_host (.clock(clock), .seq_in(seq_in), .udma_start(udma_start),
        .udma_base_limit(udma_base_limit));

    hic_config_top u_dut (.clock(clock), .rstn(rstn), .address(address),
        .byteenable(4'h1), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .seq_in(seq_in),
        .udma_start(udma_start), .udma_base_limit(udma_base_limit), .seq_out(seq_out),
        .udma_busy(), .udma_done(), .irq(irq));

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 20);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        chk(32'(waitrequest), 32'h0);
    endtask

    task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset;
        rdc(hic_pkg::OFF_CONFIG_ONE, 32'hff, {24'h0, hic_pkg::CFG_RESET});
        rdc(hic_pkg::OFF_IRQ_MASK, 32'hffffffff, 32'h0);
        bus(1'b1, 5'h18, 32'hff);
        rdc(5'h18, 32'hffffffff, 32'h0);
    endtask

    task automatic t_flush;
        repeat (14) u_host.pulse(5'h10, 16'h0000);
        rdc(hic_pkg::OFF_SEQ_STATUS, 32'hf00, 32'hc00);
        bus(1'b1, hic_pkg::OFF_CONFIG_ONE, 32'h0);
        rdc(hic_pkg::OFF_SEQ_STATUS, 32'hf00, 32'hc00);
        bus(1'b1, hic_pkg::OFF_CONFIG_ONE, 32'h10);
        rdc(hic_pkg::OFF_SEQ_STATUS, 32'hf00, 32'h0);
        rdc(hic_pkg::OFF_CONFIG_ONE, 32'hff, 32'h0);
        u_host.pulse(5'h10, 16'h0000);
        rdc(hic_pkg::OFF_SEQ_STATUS, 32'hf00, 32'h100);
    endtask

    task automatic t_clear;
        repeat (2) u_host.pulse(5'h08, 16'h0000);
        u_host.pulse(5'h04, 16'h0040);
        rdc(hic_pkg::OFF_COUNTERS, 32'hffffffff, 32'h00400002);
        bus(1'b1, hic_pkg::OFF_CONFIG_ONE, 32'h0);
        rdc(hic_pkg::OFF_COUNTERS, 32'hffffffff, 32'h00400002);
        bus(1'b1, hic_pkg::OFF_CONFIG_ONE, 32'h2);
        rdc(hic_pkg::OFF_COUNTERS, 32'hffffffff, 32'h0);
        u_host.pulse(5'h08, 16'h0000);
        rdc(hic_pkg::OFF_COUNTERS, 32'hffffffff, 32'h1);
    endtask

    task automatic t_ultra;
        bus(1'b1, hic_pkg::OFF_CONFIG_ONE, 32'he0);
        u_host.pulse(5'h01, 16'h0000);
        @(posedge clock);
        chk(32'(seq_out[2:0]), 32'h3);
        bus(1'b1, hic_pkg::OFF_CONFIG_ONE, 32'h0);
        u_host.pulse(5'h01, 16'h0000);
        @(posedge clock);
        chk(32'(seq_out[2:0]), 32'h4);
        chk(32'(irq), 32'h0);
        bus(1'b1, hic_pkg::OFF_IRQ_MASK, 32'h4);
        repeat (2) @(posedge clock);
        chk(32'(irq), 32'h1);
        rdc(hic_pkg::OFF_IRQ_STATUS, 32'h7, 32'h4);
        bus(1'b1, hic_pkg::OFF_IRQ_STATUS, 32'h4);
        repeat (2) @(posedge clock);
        chk(32'(irq), 32'h0);
        rdc(hic_pkg::OFF_IRQ_STATUS, 32'h7, 32'h0);
    endtask

    task automatic t_suspend;
        u_host.levels(1'b1, 1'b0, 1'b1);
        bus(1'b1, hic_pkg::OFF_CONFIG_ONE, 32'h4);
        u_host.pulse(5'h02, 16'h0000);
        @(posedge clock);
        chk(32'({seq_out.host_bsy, seq_out.host_drq}), 32'h2);
        rdc(hic_pkg::OFF_SEQ_STATUS, 32'h47, 32'h43);
        chk(32'(seq_out.dtei_irq), 32'h1);
        bus(1'b1, hic_pkg::OFF_CONFIG_ONE, 32'h0);
        repeat (3) @(posedge clock);
        rdc(hic_pkg::OFF_SEQ_STATUS, 32'h47, 32'h04);
        u_host.pulse(5'h02, 16'h0000);
        repeat (2) @(posedge clock);
        chk(32'({seq_out.dtei_flag, seq_out.dtei_irq, seq_out.host_bsy}), 32'h4);
    endtask

    task automatic t_timer;
        int n;
        n = 0;
        bus(1'b1, hic_pkg::OFF_ULTRA_LOW, 32'h2);
        bus(1'b1, hic_pkg::OFF_CONFIG_ONE, 32'h1);
        rdc(hic_pkg::OFF_CONFIG_ONE, 32'hff, 32'h1);
        u_host.start_timer(8'h05);
        while (u_dut.udma_done !== 1'b1 && n < 100)
        begin
            @(posedge clock);
            n++;
        end
        chk({u_dut.udma_busy, 31'(n)}, 32'h10);
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        t_reset;
        t_flush;
        t_clear;
        t_ultra;
        t_suspend;
        t_timer;
        stop_test;
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clock);
        n_fail++;
        stop_test;
    end
endmodule // host_if_sequencer_config_controls_tb_top
